// File: vpil_consts.svh
`ifndef VPIL_CONSTS_SVH
`define VPIL_CONSTS_SVH
// Interrupt locations
`define VPIL_VEC_POWER 16'h0004
`define VPIL_VEC_PROTECT 16'h0005
`define VPIL_VEC_BLK1 16'h0006
`define VPIL_VEC_BLK2 16'h0007
`define VPIL_VEC_IO_BASE 16'h0008
`define VPIL_IO_CHANNELS 56
// Select codes
`define VPIL_SC_MASTER 6'h00
`define VPIL_SC_CIR 6'h04
`define VPIL_SC_PROTECT 6'h05
// Violation register layout
`define VPIL_VIOL_PARITY_BIT 15
`define VPIL_ADDR_W 15
// Lowest protectable address; 0 and 1 are the accumulators
`define VPIL_FIRST_PROTECTED 15'h0002
`define VPIL_INDIRECT_RELEASE 2'h3
// Instructions to complete after a grant before interrupts reopen
`define VPIL_GRANT_HOLD 2'h2
`define VPIL_RESET_FENCE 15'h0000
`endif

// File: vpil_pkg.sv
package vpil_pkg;
  typedef enum logic [2:0] {
    VPIL_OP_SET_CONTROL,
    VPIL_OP_CLEAR_CONTROL,
    VPIL_OP_SET_FLAG,
    VPIL_OP_CLEAR_FLAG,
    VPIL_OP_SKIP_SET,
    VPIL_OP_SKIP_CLEAR,
    VPIL_OP_LOAD,
    VPIL_OP_OUTPUT
  } vpil_io_op_e;

  typedef struct packed {
    logic valid;
    vpil_io_op_e op;
    logic [5:0] sel;
    logic [15:0] data;
  } vpil_io_cmd_s;

  typedef struct packed {
    logic done;
    logic is_io;
    logic indirect_jump;
    logic [14:0] addr;
  } vpil_instr_s;

  typedef struct packed {
    logic valid;
    logic restricted;
    logic final_level;
    logic [14:0] addr;
  } vpil_mem_ref_s;
endpackage

// File: vpil_ctrl.sv
`timescale 1ns/10ps
`include "vpil_consts.svh"
module vpil_ctrl (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic cycle_end,
  input wire vpil_pkg::vpil_instr_s instr,
  input wire vpil_pkg::vpil_io_cmd_s io_cmd,
  input wire vpil_pkg::vpil_mem_ref_s mem_ref,
  input wire logic indirect_level,
  input wire logic protect_installed,
  input wire logic parity_switch_int,
  input wire logic parity_error,
  input wire logic [14:0] parity_addr,
  input wire logic mapping_violation,
  input wire logic power_fail,
  input wire logic blk_busy,
  input wire logic blk1_done,
  input wire logic blk2_done,
  input wire logic [55:0] card_request,
  output logic int_req,
  output logic hold_pc,
  output logic [15:0] int_vector,
  output logic [15:0] read_data,
  output logic read_valid,
  output logic skip,
  output logic violation,
  output logic master_enable,
  output logic protect_enable,
  output logic select05_flag
);
  logic pend_power;
  logic pend_protect;
  logic pend_blk1;
  logic pend_blk2;
  logic [15:0] protect_fault_address;
  logic [15:0] central_int;
  logic [14:0] fence;
  logic [1:0] grant_hold;
  logic ind_hold;
  logic ctl_hold;
  logic [1:0] ind_levels;
  logic next_grant;
  logic [15:0] next_vector;
  logic io_ok;
  logic sys_ok;
  logic io_found;
  logic [5:0] io_index;
  logic prot_fault;
  logic parity_int;
  logic is_sel_cmd;

  function automatic logic [6:0] lowest_set(input logic [55:0] v);
    logic [6:0] r;
    r = 7'h00;
    for (int i = `VPIL_IO_CHANNELS - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, 6'(i)};
      end
    end
    return r;
  endfunction

  function automatic logic cmd_at(input vpil_pkg::vpil_io_cmd_s c, input logic [5:0] s,
                                  input vpil_pkg::vpil_io_op_e o);
    return c.valid && c.sel == s && c.op == o;
  endfunction

  // Fault check: addresses 0 and 1 are accumulators, never protected
  assign prot_fault = protect_enable && mem_ref.valid && mem_ref.restricted && mem_ref.final_level
                      && mem_ref.addr >= `VPIL_FIRST_PROTECTED && mem_ref.addr < fence;
  assign parity_int = parity_error && parity_switch_int && protect_installed && select05_flag;
  assign is_sel_cmd = io_cmd.valid && io_cmd.op inside {vpil_pkg::VPIL_OP_SET_CONTROL,
    vpil_pkg::VPIL_OP_CLEAR_CONTROL, vpil_pkg::VPIL_OP_SET_FLAG, vpil_pkg::VPIL_OP_CLEAR_FLAG,
    vpil_pkg::VPIL_OP_SKIP_SET, vpil_pkg::VPIL_OP_SKIP_CLEAR};

  // Card requests already carry flag and control; master enable is gated in io_ok; the chain is the priority walk
  assign {io_found, io_index} = lowest_set(card_request);
  assign sys_ok = grant_hold == 2'h0 && !ctl_hold;
  assign io_ok = sys_ok && master_enable && !blk_busy
                 && (!ind_hold || (protect_installed && ind_levels == `VPIL_INDIRECT_RELEASE));

  always_comb begin
    next_grant = 1'b0;
    next_vector = 16'h0000;
    if (cycle_end && grant_hold == 2'h0) begin
      if (pend_power) begin
        next_grant = 1'b1;
        next_vector = `VPIL_VEC_POWER;
      end else if (pend_protect) begin
        next_grant = 1'b1;
        next_vector = `VPIL_VEC_PROTECT;
      end else if (sys_ok && !ind_hold && master_enable && pend_blk1) begin
        next_grant = 1'b1;
        next_vector = `VPIL_VEC_BLK1;
      end else if (sys_ok && !ind_hold && master_enable && pend_blk2) begin
        next_grant = 1'b1;
        next_vector = `VPIL_VEC_BLK2;
      end else if (io_ok && io_found) begin
        next_grant = 1'b1;
        next_vector = `VPIL_VEC_IO_BASE + {10'h000, io_index};
      end
    end
  end

  // Pending events; a new event in the grant cycle survives the clear
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pend_power <= 1'b0;
      pend_protect <= 1'b0;
      pend_blk1 <= 1'b0;
      pend_blk2 <= 1'b0;
    end else begin
      pend_power <= power_fail || (pend_power && !(next_grant && next_vector == `VPIL_VEC_POWER));
      pend_protect <= prot_fault || parity_int
                      || (pend_protect && !(next_grant && next_vector == `VPIL_VEC_PROTECT));
      pend_blk1 <= blk1_done || (pend_blk1 && !(next_grant && next_vector == `VPIL_VEC_BLK1));
      pend_blk2 <= blk2_done || (pend_blk2 && !(next_grant && next_vector == `VPIL_VEC_BLK2));
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      int_req <= 1'b0;
      hold_pc <= 1'b0;
      int_vector <= 16'h0000;
      central_int <= 16'h0000;
    end else begin
      int_req <= next_grant;
      hold_pc <= next_grant;
      if (next_grant) begin
        int_vector <= next_vector;
        central_int <= next_vector;
      end
    end
  end

  // Inhibit windows counted in completed instructions
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      grant_hold <= 2'h0;
    end else if (next_grant) begin
      grant_hold <= `VPIL_GRANT_HOLD;
    end else if (instr.done && grant_hold != 2'h0) begin
      grant_hold <= grant_hold - 2'h1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ind_hold <= 1'b0;
      ctl_hold <= 1'b0;
    end else begin
      if (instr.done) begin
        ind_hold <= instr.indirect_jump;
      end
      // Set wins: a command in the completing instruction still defers the next one
      if (is_sel_cmd) begin
        ctl_hold <= 1'b1;
      end else if (instr.done) begin
        ctl_hold <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ind_levels <= 2'h0;
    end else if (instr.done) begin
      ind_levels <= 2'h0;
    end else if (indirect_level && ind_levels != `VPIL_INDIRECT_RELEASE) begin
      ind_levels <= ind_levels + 2'h1;
    end
  end

  // Master enable and the select 05 flag
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      master_enable <= 1'b0;
    end else if (cmd_at(io_cmd, `VPIL_SC_MASTER, vpil_pkg::VPIL_OP_SET_FLAG)) begin
      master_enable <= 1'b1;
    end else if (cmd_at(io_cmd, `VPIL_SC_MASTER, vpil_pkg::VPIL_OP_CLEAR_FLAG)) begin
      master_enable <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      select05_flag <= 1'b0;
    end else if (mapping_violation) begin
      select05_flag <= 1'b1;
    end else if (cmd_at(io_cmd, `VPIL_SC_PROTECT, vpil_pkg::VPIL_OP_SET_FLAG)) begin
      select05_flag <= 1'b1;
    end else if (cmd_at(io_cmd, `VPIL_SC_PROTECT, vpil_pkg::VPIL_OP_CLEAR_FLAG)) begin
      select05_flag <= 1'b0;
    end
  end

  // Protection enable: a grant drops it once the vector instruction proves not to be I/O
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      protect_enable <= 1'b0;
    end else if (cmd_at(io_cmd, `VPIL_SC_PROTECT, vpil_pkg::VPIL_OP_SET_CONTROL) && protect_installed) begin
      protect_enable <= 1'b1;
    end else if (cmd_at(io_cmd, `VPIL_SC_PROTECT, vpil_pkg::VPIL_OP_CLEAR_CONTROL)) begin
      protect_enable <= 1'b0;
    end else if (instr.done && grant_hold == `VPIL_GRANT_HOLD && !instr.is_io) begin
      protect_enable <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fence <= `VPIL_RESET_FENCE;
    end else if (cmd_at(io_cmd, `VPIL_SC_PROTECT, vpil_pkg::VPIL_OP_OUTPUT)) begin
      fence <= io_cmd.data[14:0];
    end
  end

  // Parity wins if both land together; it is the rarer and harder to reproduce
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      protect_fault_address <= 16'h0000;
      violation <= 1'b0;
    end else begin
      violation <= prot_fault;
      if (parity_int) begin
        protect_fault_address <= {1'b1, parity_addr};
      end else if (prot_fault) begin
        protect_fault_address <= {1'b0, instr.addr};
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      read_data <= 16'h0000;
      read_valid <= 1'b0;
      skip <= 1'b0;
    end else begin
      read_valid <= 1'b0;
      skip <= 1'b0;
      if (cmd_at(io_cmd, `VPIL_SC_CIR, vpil_pkg::VPIL_OP_LOAD)) begin
        read_data <= central_int;
        read_valid <= 1'b1;
      end else if (cmd_at(io_cmd, `VPIL_SC_PROTECT, vpil_pkg::VPIL_OP_LOAD)) begin
        read_data <= protect_fault_address;
        read_valid <= 1'b1;
      end
      if (io_cmd.valid && io_cmd.sel == `VPIL_SC_PROTECT) begin
        skip <= (io_cmd.op == vpil_pkg::VPIL_OP_SKIP_SET && select05_flag)
                || (io_cmd.op == vpil_pkg::VPIL_OP_SKIP_CLEAR && !select05_flag);
      end else if (io_cmd.valid && io_cmd.sel == `VPIL_SC_MASTER) begin
        skip <= (io_cmd.op == vpil_pkg::VPIL_OP_SKIP_SET && master_enable)
                || (io_cmd.op == vpil_pkg::VPIL_OP_SKIP_CLEAR && !master_enable);
      end
    end
  end

  sequence grant_s;
    int_req;
  endsequence

  sequence last_done_s;
    instr.done && grant_hold == 2'h1 && !next_grant;
  endsequence

  no_regrant_a: assert property (@(posedge clk) disable iff (!reset_n)
    int_req |=> !int_req [*2]) else $error("Grant repeated inside inhibit window");

  hold_count_a: assert property (@(posedge clk) disable iff (!reset_n)
    grant_s |-> grant_hold == `VPIL_GRANT_HOLD) else $error("Inhibit not armed on grant");

  master_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
    int_req && int_vector >= `VPIL_VEC_IO_BASE |-> $past(master_enable) && !$past(blk_busy))
    else $error("I/O grant with system or block channel blocking");

  io_vector_a: assert property (@(posedge clk) disable iff (!reset_n)
    next_grant && next_vector >= `VPIL_VEC_IO_BASE |-> next_vector == 16'h0008 + {10'h000, io_index}
      && next_vector <= 16'h003f) else $error("I/O vector out of range");

  lowest_wins_a: assert property (@(posedge clk) disable iff (!reset_n)
    next_grant && next_vector >= `VPIL_VEC_IO_BASE |-> card_request[io_index]
      && (card_request & ~({56{1'b1}} << io_index)) == 56'h0)
    else $error("Granted channel not raised");

  blk_order_a: assert property (@(posedge clk) disable iff (!reset_n)
    next_grant && next_vector == `VPIL_VEC_BLK2 |-> !pend_blk1) else $error("Channel 2 beat channel 1");

  cir_store_a: assert property (@(posedge clk) disable iff (!reset_n)
    next_grant |=> central_int == $past(next_vector)) else $error("Central register missed grant");

  parity_mark_a: assert property (@(posedge clk) disable iff (!reset_n)
    parity_int |=> protect_fault_address == {1'b1, $past(parity_addr)}) else $error("Parity mark wrong");

  acc_free_a: assert property (@(posedge clk) disable iff (!reset_n)
    mem_ref.valid && mem_ref.addr < `VPIL_FIRST_PROTECTED |-> !prot_fault) else $error("Accumulator faulted");

  master_set_a: assert property (@(posedge clk) disable iff (!reset_n)
    cmd_at(io_cmd, `VPIL_SC_MASTER, vpil_pkg::VPIL_OP_SET_FLAG) |=> master_enable)
    else $error("Master enable not set");

  ind_block_a: assert property (@(posedge clk) disable iff (!reset_n)
    ind_hold && !(protect_installed && ind_levels == `VPIL_INDIRECT_RELEASE) |-> !(next_grant
      && next_vector >= `VPIL_VEC_BLK1)) else $error("Interrupt inside indirect hold");

  reopen_a: assert property (@(posedge clk) disable iff (!reset_n)
    last_done_s |=> grant_hold == 2'h0) else $error("Inhibit did not clear");

  map_flag_a: assert property (@(posedge clk) disable iff (!reset_n)
    mapping_violation |=> select05_flag)
    else $error("Mapping violation left flag clear");

  ctl_defer_a: assert property (@(posedge clk) disable iff (!reset_n)
    ctl_hold |-> !(next_grant && next_vector >= `VPIL_VEC_BLK1))
    else $error("Grant inside control defer");

  prot_drop_a: assert property (@(posedge clk) disable iff (!reset_n)
    instr.done && grant_hold == `VPIL_GRANT_HOLD && !instr.is_io && !io_cmd.valid |=> !protect_enable)
    else $error("Protection stayed on after grant");

  power_first_a: assert property (@(posedge clk) disable iff (!reset_n)
    next_grant && pend_power |-> next_vector == `VPIL_VEC_POWER)
    else $error("Power fail not taken first");
endmodule

// File: vpil_card_model.sv
`timescale 1ns/10ps
module vpil_card_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire vpil_pkg::vpil_io_cmd_s io_cmd,
  input wire logic [55:0] dev_raise,
  output logic [55:0] card_request
);
  logic [55:0] flag;
  logic [55:0] control;
  logic [56:0] chain;
  logic hit;
  logic [5:0] idx;

  assign hit = io_cmd.valid && (io_cmd.sel >= 6'h08);
  assign idx = io_cmd.sel - 6'h08;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      control <= '0;
    end else if (hit && io_cmd.op == vpil_pkg::VPIL_OP_SET_CONTROL) begin
      control[idx] <= 1'b1;
    end else if (hit && io_cmd.op == vpil_pkg::VPIL_OP_CLEAR_CONTROL) begin
      control[idx] <= 1'b0;
    end
  end

  // Only a clear-flag command drops a flag; the device can only raise it
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flag <= '0;
    end else begin
      flag <= flag | dev_raise;
      if (hit && io_cmd.op == vpil_pkg::VPIL_OP_SET_FLAG) begin
        flag[idx] <= 1'b1;
      end else if (hit && io_cmd.op == vpil_pkg::VPIL_OP_CLEAR_FLAG) begin
        flag[idx] <= 1'b0;
      end
    end
  end

  // A card with control and flag set breaks the chain for every higher-numbered card
  always_comb begin
    chain[0] = 1'b1;
    for (int i = 0; i < 56; i++) begin
      chain[i + 1] = chain[i] & ~(flag[i] & control[i]);
      card_request[i] = flag[i] & control[i] & chain[i];
    end
  end
endmodule

// File: vpil_ctrl_tb.sv
`timescale 1ns/10ps
module vpil_ctrl_tb;
  logic clk, reset_n, blk_busy, blk1_done, blk2_done, power_fail, parity_error;
  logic cycle_end, indirect_level, mapping_violation;
  vpil_pkg::vpil_instr_s instr;
  vpil_pkg::vpil_io_cmd_s io_cmd;
  vpil_pkg::vpil_mem_ref_s mem_ref;
  logic [14:0] parity_addr;
  logic [55:0] card_request, dev_raise;
  logic int_req, hold_pc, read_valid, skip, violation, master_enable, protect_enable, select05_flag;
  logic [15:0] int_vector, read_data;
  int mismatches = 0;
  int check_count = 0;

  vpil_ctrl u_vpil_ctrl (.clk(clk), .reset_n(reset_n), .cycle_end(cycle_end), .instr(instr), .io_cmd(io_cmd),
    .mem_ref(mem_ref), .indirect_level(indirect_level), .protect_installed(1'b1), .parity_switch_int(1'b1),
    .parity_error(parity_error), .parity_addr(parity_addr), .mapping_violation(mapping_violation),
    .power_fail(power_fail), .blk_busy(blk_busy), .blk1_done(blk1_done), .blk2_done(blk2_done),
    .card_request(card_request), .int_req(int_req), .hold_pc(hold_pc), .int_vector(int_vector),
    .read_data(read_data), .read_valid(read_valid), .skip(skip), .violation(violation),
    .master_enable(master_enable), .protect_enable(protect_enable), .select05_flag(select05_flag));

  vpil_card_model u_vpil_card_model (.clk(clk), .reset_n(reset_n), .io_cmd(io_cmd), .dev_raise(dev_raise),
    .card_request(card_request));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cmd(input vpil_pkg::vpil_io_op_e op, input logic [5:0] sel, input logic [15:0] d);
    @(negedge clk);
    io_cmd = '{1'b1, op, sel, d};
    @(negedge clk);
    io_cmd.valid = 1'b0;
  endtask

  task automatic load(input logic [5:0] sel, input logic [15:0] e);
    cmd(vpil_pkg::VPIL_OP_LOAD, sel, 16'h0000);
    chk("read_valid", 16'h0001, {15'h0000, read_valid});
    chk("read_data", e, read_data);
  endtask

  // One completed instruction, as the sequencer reports it
  task automatic step();
    @(negedge clk);
    instr.done = 1'b1;
    @(negedge clk);
    instr.done = 1'b0;
  endtask

  task automatic quiet(input int n);
    int hit;
    hit = 0;
    repeat (n) begin
      @(negedge clk);
      if (int_req !== 1'b0) hit = 1;
    end
    chk("no_grant", 16'h0000, 16'(hit));
  endtask

  task automatic raise(input logic [55:0] m);
    @(negedge clk);
    dev_raise = m;
    @(negedge clk);
    dev_raise = '0;
  endtask

  // Two completions must pass after a grant before anything else may be taken
  task automatic grant(input logic [15:0] v, input logic [5:0] clr);
    int n;
    n = 0;
    while (int_req !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk("int_req", 16'h0001, {15'h0000, int_req});
    chk("int_vector", v, int_vector);
    chk("hold_pc", 16'h0001, {15'h0000, hold_pc});
    if (clr != 6'h00) cmd(vpil_pkg::VPIL_OP_CLEAR_FLAG, clr, 16'h0000);
    step();
    step();
  endtask

  task automatic t_io();
    chk("master_enable", 16'h0000, {15'h0000, master_enable});
    quiet(4);
    cmd(vpil_pkg::VPIL_OP_SET_FLAG, 6'h00, 16'h0000);
    chk("master_enable", 16'h0001, {15'h0000, master_enable});
    raise(56'h4);
    cmd(vpil_pkg::VPIL_OP_SET_CONTROL, 6'h0a, 16'h0000);
    quiet(6);
    step();
    grant(16'h000a, 6'h0a);
    $display("done t_io");
  endtask

  task automatic t_prio();
    cmd(vpil_pkg::VPIL_OP_SET_CONTROL, 6'h0b, 16'h0000);
    cmd(vpil_pkg::VPIL_OP_SET_CONTROL, 6'h0d, 16'h0000);
    step();
    raise(56'h28);
    grant(16'h000b, 6'h0b);
    grant(16'h000d, 6'h0d);
    $display("done t_prio");
  endtask

  task automatic t_blk();
    blk_busy = 1'b1;
    raise(56'h4);
    quiet(8);
    blk_busy = 1'b0;
    grant(16'h000a, 6'h0a);
    @(negedge clk);
    blk1_done = 1'b1;
    blk2_done = 1'b1;
    @(negedge clk);
    blk1_done = 1'b0;
    blk2_done = 1'b0;
    grant(16'h0006, 6'h00);
    grant(16'h0007, 6'h00);
    $display("done t_blk");
  endtask

  task automatic t_master();
    cmd(vpil_pkg::VPIL_OP_CLEAR_FLAG, 6'h00, 16'h0000);
    step();
    chk("master_enable", 16'h0000, {15'h0000, master_enable});
    raise(56'h4);
    quiet(8);
    @(negedge clk);
    power_fail = 1'b1;
    @(negedge clk);
    power_fail = 1'b0;
    grant(16'h0004, 6'h00);
    cmd(vpil_pkg::VPIL_OP_SET_FLAG, 6'h00, 16'h0000);
    step();
    grant(16'h000a, 6'h0a);
    load(6'h04, 16'h000a);
    $display("done t_master");
  endtask

  task automatic t_fault();
    instr.addr = 15'h0123;
    cmd(vpil_pkg::VPIL_OP_OUTPUT, 6'h05, 16'h0100);
    cmd(vpil_pkg::VPIL_OP_SET_CONTROL, 6'h05, 16'h0000);
    step();
    chk("protect_enable", 16'h0001, {15'h0000, protect_enable});
    @(negedge clk);
    mem_ref = '{1'b1, 1'b1, 1'b1, 15'h0001};
    @(negedge clk);
    mem_ref.valid = 1'b0;
    chk("violation", 16'h0000, {15'h0000, violation});
    quiet(6);
    mem_ref = '{1'b1, 1'b0, 1'b1, 15'h0050};
    @(negedge clk);
    mem_ref.valid = 1'b0;
    chk("violation", 16'h0000, {15'h0000, violation});
    quiet(6);
    @(negedge clk);
    mem_ref = '{1'b1, 1'b1, 1'b1, 15'h0050};
    @(negedge clk);
    mem_ref.valid = 1'b0;
    chk("violation", 16'h0001, {15'h0000, violation});
    grant(16'h0005, 6'h00);
    chk("protect_enable", 16'h0000, {15'h0000, protect_enable});
    load(6'h05, 16'h0123);
    cmd(vpil_pkg::VPIL_OP_SET_FLAG, 6'h05, 16'h0000);
    chk("select05_flag", 16'h0001, {15'h0000, select05_flag});
    step();
    @(negedge clk);
    parity_addr = 15'h0456;
    parity_error = 1'b1;
    @(negedge clk);
    parity_error = 1'b0;
    grant(16'h0005, 6'h00);
    load(6'h05, 16'h8456);
    load(6'h04, 16'h0005);
    $display("done t_fault");
  endtask

  task automatic t_hold();
    cmd(vpil_pkg::VPIL_OP_CLEAR_FLAG, 6'h05, 16'h0000);
    chk("select05_flag", 16'h0000, {15'h0000, select05_flag});
    @(negedge clk);
    mapping_violation = 1'b1;
    @(negedge clk);
    mapping_violation = 1'b0;
    chk("select05_flag", 16'h0001, {15'h0000, select05_flag});
    cmd(vpil_pkg::VPIL_OP_SKIP_SET, 6'h05, 16'h0000);
    chk("skip", 16'h0001, {15'h0000, skip});
    instr.indirect_jump = 1'b1;
    step();
    instr.indirect_jump = 1'b0;
    raise(56'h4);
    quiet(6);
    indirect_level = 1'b1;
    repeat (3) @(negedge clk);
    indirect_level = 1'b0;
    grant(16'h000a, 6'h0a);
    cycle_end = 1'b0;
    raise(56'h4);
    quiet(6);
    cycle_end = 1'b1;
    grant(16'h000a, 6'h0a);
    $display("done t_hold");
  endtask

  initial begin
    reset_n = 1'b0;
    instr = '0;
    io_cmd = '0;
    mem_ref = '0;
    dev_raise = '0;
    parity_addr = '0;
    {blk_busy, blk1_done, blk2_done, power_fail, parity_error} = '0;
    {indirect_level, mapping_violation} = '0;
    cycle_end = 1'b1;
    repeat (16) @(negedge clk);
    reset_n = 1'b1;
    t_io();
    t_prio();
    t_blk();
    t_master();
    t_fault();
    t_hold();
    close_out();
  end

  initial begin
    #(50 * 5000);
    mismatches++;
    close_out();
  end
endmodule
